// >>> design/psdc_consts.svh
// Offsets, field positions, reset values and counts of the synthesizer core.
// Included by the core only; definitions only.
`ifndef PSDC_CONSTS_SVH
`define PSDC_CONSTS_SVH

`define PSDC_WORD_W 17
`define PSDC_SWAL_LSB 0
`define PSDC_SWAL_W 7
`define PSDC_MAIN_LSB 7
`define PSDC_MAIN_W 10
`define PSDC_MAIN_MIN 10'h005
`define PSDC_REF_W 11
`define PSDC_SYNC_N 3

`define PSDC_CTRL_OFS 8'h00
`define PSDC_STAT_OFS 8'h04
`define PSDC_WORD_OFS 8'h08
`define PSDC_FLAG_OFS 8'h0c
`define PSDC_CYC_OFS 8'h10

`define PSDC_CTRL_RATIO_BIT 0
`define PSDC_CTRL_PUMP_BIT 1
`define PSDC_CTRL_RST 2'h2

`define PSDC_FLAG_MAIN_BIT 0
`define PSDC_FLAG_SWAL_BIT 1
`define PSDC_FLAG_UNLK_BIT 2

`define PSDC_RESP_OKAY 2'h0
`define PSDC_RESP_SLVERR 2'h2

`endif

// >>> design/psdc_pkg.sv
// Types shared by the synthesizer core and its comparator and divider.
// Assumes the constants header is compiled alongside.
package psdc_pkg;

  typedef enum logic [1:0] {
    PSDC_PUMP_OFF,
    PSDC_PUMP_UP,
    PSDC_PUMP_DN
  } psdc_pump_t;

  typedef struct packed {
    logic [9:0] main;
    logic [6:0] swallow;
  } psdc_word_t;

endpackage

// >>> design/psdc_cmp_if.sv
// Signals passed between the core, the feedback divider and the comparator.
// All members live in the aclk domain.
`timescale 1ns/1ns
interface psdc_cmp_if;
  import psdc_pkg::*;

  logic ref_tick;
  logic div_tick;
  logic fin_fall;
  logic mod_hi;
  psdc_word_t word;
  psdc_pump_t pump_st;

  modport core (
    output ref_tick,
    output fin_fall,
    output word,
    input div_tick,
    input mod_hi,
    input pump_st
  );

  modport fdiv (
    input fin_fall,
    input word,
    output div_tick,
    output mod_hi
  );

  modport pfd (
    input ref_tick,
    input div_tick,
    output pump_st
  );
endinterface

// >>> design/psdc_fdiv.sv
// Pulse-swallow feedback divider: counts falling edges of the feedback input.
// Assumes fin_fall is a one-cycle pulse on aclk, one per prescaler cycle.
`timescale 1ns/1ns
module psdc_fdiv (
  input wire logic aclk,
  input wire logic aresetn,
  psdc_cmp_if.fdiv cmp
);
  import psdc_pkg::*;

  logic [9:0] main_cnt_r;
  logic [6:0] swal_cnt_r;
  logic mod_hi_r;
  logic div_tick_r;

  // Counters reload at the end of each main cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      main_cnt_r <= 10'h001;
      swal_cnt_r <= 7'h00;
    end else if (cmp.fin_fall) begin
      if (main_cnt_r <= 10'h001) begin
        main_cnt_r <= cmp.word.main;
        swal_cnt_r <= cmp.word.swallow;
      end else begin
        main_cnt_r <= main_cnt_r - 10'h001;
        if (swal_cnt_r != 7'h00) begin
          swal_cnt_r <= swal_cnt_r - 7'h01;
        end
      end
    end
  end

  // Moves only on a falling feedback edge, so the prescaler never sees a
  // modulus change mid-cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mod_hi_r <= 1'b0;
    end else if (cmp.fin_fall) begin
      if (main_cnt_r <= 10'h001) begin
        mod_hi_r <= (cmp.word.swallow != 7'h00);
      end else begin
        mod_hi_r <= (swal_cnt_r > 7'h01);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_tick_r <= 1'b0;
    end else begin
      div_tick_r <= cmp.fin_fall && (main_cnt_r <= 10'h001);
    end
  end

  assign cmp.mod_hi = mod_hi_r;
  assign cmp.div_tick = div_tick_r;
endmodule

// >>> design/psdc_pfd.sv
// Edge-triggered phase/frequency comparator on the two compare ticks.
// Assumes both ticks are one-cycle pulses on aclk.
`timescale 1ns/1ns
module psdc_pfd (
  input wire logic aclk,
  input wire logic aresetn,
  psdc_cmp_if.pfd cmp
);
  import psdc_pkg::*;

  psdc_pump_t st_r;

  // Ticks in the same cycle cancel: the phase error is below one clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= PSDC_PUMP_OFF;
    end else begin
      case (st_r)
        PSDC_PUMP_OFF: begin
          if (cmp.ref_tick && !cmp.div_tick) begin
            st_r <= PSDC_PUMP_UP;
          end else if (cmp.div_tick && !cmp.ref_tick) begin
            st_r <= PSDC_PUMP_DN;
          end
        end
        PSDC_PUMP_UP: begin
          if (cmp.div_tick) begin
            st_r <= PSDC_PUMP_OFF;
          end
        end
        PSDC_PUMP_DN: begin
          if (cmp.ref_tick) begin
            st_r <= PSDC_PUMP_OFF;
          end
        end
        default: begin
          st_r <= PSDC_PUMP_OFF;
        end
      endcase
    end
  end

  assign cmp.pump_st = st_r;
endmodule

// >>> design/psdc_core.sv
// Digital core of a serial-programmed PLL frequency synthesizer.
// Assumes an AXI4-Lite master on aclk; serial port clocked by ser_clk;
// feedback, oscillator, strobe and select pins are asynchronous to aclk.
//
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
`include "psdc_consts.svh"
module psdc_core #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic load_strobe,
  input wire logic fin,
  input wire logic osc_input,
  input wire logic [2:0] ref_sel,
  output logic osc_output,
  output logic modulus_ctrl,
  output logic prescaler_ratio_select,
  output logic lock_indicator,
  output logic pump_o,
  output logic pump_oe,
  output logic ref_phase_o,
  output logic div_phase_o,
  output logic div_phase_oe
);
  import psdc_pkg::*;

  localparam int PIN_N = 6;
  localparam int P_LOAD = 0;
  localparam int P_FIN = 1;
  localparam int P_OSC = 2;
  localparam int P_SEL = 3;

  psdc_cmp_if cmp ();

  logic [`PSDC_WORD_W-1:0] shift_r;
  logic [PIN_N-1:0] pins;
  logic [PIN_N-1:0] s1_r;
  logic [PIN_N-1:0] s2_r;
  logic [PIN_N-1:0] s3_r;
  logic [PIN_N-1:0] st_r;
  logic [PIN_N-1:0] st_d_r;
  logic fin_fall_r;
  logic osc_rise;
  logic [`PSDC_WORD_W-1:0] word_r;
  logic [`PSDC_REF_W-1:0] ref_cnt_r;
  logic [`PSDC_REF_W-1:0] ref_last;
  logic ref_tick_r;
  logic [1:0] ctrl_r;
  logic [2:0] flag_r;
  logic [15:0] cyc_r;
  logic aw_got_r;
  logic w_got_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic write_do;
  logic [31:0] rd_mux;
  logic rd_hit;
  logic wr_hit;
  logic pump_en;

  // Link domain: the shift register is the only logic on ser_clk
  always_ff @(posedge ser_clk) begin
    shift_r <= {shift_r[`PSDC_WORD_W-2:0], ser_data};
  end

  // Pin synchronisers: a level counts once stages two and three agree
  assign pins = {ref_sel, osc_input, fin, load_strobe};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= pins;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi++) begin : g_pin
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          st_r[gi] <= 1'b0;
          st_d_r[gi] <= 1'b0;
        end else begin
          if (s2_r[gi] == s3_r[gi]) begin
            st_r[gi] <= s3_r[gi];
          end
          st_d_r[gi] <= st_r[gi];
        end
      end
    end
  endgenerate

  // Word crossing: the host keeps ser_clk still while the strobe is high,
  // so shift_r is static whenever it is sampled here. A strobe raised
  // mid-shift may latch a torn word; that is a host fault.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      word_r <= '0;
    end else if (st_r[P_LOAD] && st_d_r[P_LOAD]) begin
      word_r <= shift_r;
    end
  end

  assign cmp.word = psdc_word_t'(word_r);

  // Feedback edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fin_fall_r <= 1'b0;
    end else begin
      fin_fall_r <= st_d_r[P_FIN] && !st_r[P_FIN];
    end
  end

  assign cmp.fin_fall = fin_fall_r;

  // Reference divider on oscillator rising edges
  always_comb begin
    case (st_r[P_SEL+2:P_SEL])
      3'h0: ref_last = 11'h007;
      3'h1: ref_last = 11'h00f;
      3'h2: ref_last = 11'h03f;
      3'h3: ref_last = 11'h07f;
      3'h4: ref_last = 11'h0ff;
      3'h5: ref_last = 11'h1ff;
      3'h6: ref_last = 11'h3ff;
      default: ref_last = 11'h7ff;
    endcase
  end

  assign osc_rise = st_r[P_OSC] && !st_d_r[P_OSC];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_cnt_r <= '0;
      ref_tick_r <= 1'b0;
    end else begin
      ref_tick_r <= 1'b0;
      if (osc_rise) begin
        if (ref_cnt_r >= ref_last) begin
          ref_cnt_r <= '0;
          ref_tick_r <= 1'b1;
        end else begin
          ref_cnt_r <= ref_cnt_r + 11'h001;
        end
      end
    end
  end

  assign cmp.ref_tick = ref_tick_r;

  psdc_fdiv u_fdiv (
    .aclk(aclk),
    .aresetn(aresetn),
    .cmp(cmp.fdiv)
  );

  psdc_pfd u_pfd (
    .aclk(aclk),
    .aresetn(aresetn),
    .cmp(cmp.pfd)
  );

  // Oscillator inverter: registered and inverted, so it lags the pin by the sync depth plus two cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_output <= 1'b1;
    end else begin
      osc_output <= !st_r[P_OSC];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      modulus_ctrl <= 1'b0;
    end else begin
      modulus_ctrl <= cmp.mod_hi;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prescaler_ratio_select <= 1'b0;
    end else begin
      prescaler_ratio_select <= ctrl_r[`PSDC_CTRL_RATIO_BIT];
    end
  end

  assign pump_en = ctrl_r[`PSDC_CTRL_PUMP_BIT];

  // Pump drivers; with the pump disabled both outputs float
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pump_o <= 1'b0;
      pump_oe <= 1'b0;
      ref_phase_o <= 1'b0;
      div_phase_o <= 1'b0;
      div_phase_oe <= 1'b0;
    end else begin
      div_phase_o <= 1'b0;
      case (cmp.pump_st)
        PSDC_PUMP_UP: begin
          pump_o <= 1'b1;
          pump_oe <= pump_en;
          ref_phase_o <= 1'b0;
          div_phase_oe <= pump_en;
        end
        PSDC_PUMP_DN: begin
          pump_o <= 1'b0;
          pump_oe <= pump_en;
          ref_phase_o <= 1'b1;
          div_phase_oe <= 1'b0;
        end
        default: begin
          pump_o <= 1'b0;
          pump_oe <= 1'b0;
          ref_phase_o <= 1'b0;
          div_phase_oe <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_indicator <= 1'b1;
    end else begin
      lock_indicator <= (cmp.pump_st == PSDC_PUMP_OFF);
    end
  end

  // AXI4-Lite write: address and data taken in either order
  assign write_do = aw_got_r && w_got_r && !s_axi_bvalid;
  assign wr_hit = (awaddr_r == ADDR_W'(`PSDC_CTRL_OFS)) ||
                  (awaddr_r == ADDR_W'(`PSDC_FLAG_OFS));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      s_axi_awready <= 1'b1;
      awaddr_r <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got_r <= 1'b1;
      s_axi_awready <= 1'b0;
      awaddr_r <= s_axi_awaddr;
    end else if (write_do) begin
      aw_got_r <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_r <= 1'b0;
      s_axi_wready <= 1'b1;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got_r <= 1'b1;
      s_axi_wready <= 1'b0;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (write_do) begin
      w_got_r <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PSDC_RESP_OKAY;
    end else if (write_do) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? `PSDC_RESP_OKAY : `PSDC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= `PSDC_CTRL_RST;
    end else if (write_do && wstrb_r[0] &&
                 awaddr_r == ADDR_W'(`PSDC_CTRL_OFS)) begin
      ctrl_r <= wdata_r[1:0];
    end
  end

  // Sticky flags, write one to clear; a new event wins over the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_r <= '0;
    end else begin
      if (write_do && wstrb_r[0] &&
          awaddr_r == ADDR_W'(`PSDC_FLAG_OFS)) begin
        flag_r <= flag_r & ~wdata_r[2:0];
      end
      if (cmp.word.main < `PSDC_MAIN_MIN) begin
        flag_r[`PSDC_FLAG_MAIN_BIT] <= 1'b1;
      end
      if (ctrl_r[`PSDC_CTRL_RATIO_BIT] && cmp.word.swallow[6]) begin
        flag_r[`PSDC_FLAG_SWAL_BIT] <= 1'b1;
      end
      if (cmp.pump_st != PSDC_PUMP_OFF) begin
        flag_r[`PSDC_FLAG_UNLK_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cyc_r <= '0;
    end else if (cmp.div_tick) begin
      cyc_r <= cyc_r + 16'h0001;
    end
  end

  // AXI4-Lite read
  always_comb begin
    rd_mux = '0;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      ADDR_W'(`PSDC_CTRL_OFS): rd_mux[1:0] = ctrl_r;
      ADDR_W'(`PSDC_STAT_OFS): rd_mux[3:0] = {st_r[P_SEL+2:P_SEL] == 3'h7,
        lock_indicator, modulus_ctrl, prescaler_ratio_select};
      ADDR_W'(`PSDC_WORD_OFS): rd_mux[`PSDC_WORD_W-1:0] = word_r;
      ADDR_W'(`PSDC_FLAG_OFS): rd_mux[2:0] = flag_r;
      ADDR_W'(`PSDC_CYC_OFS): rd_mux[15:0] = cyc_r;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `PSDC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_hit ? `PSDC_RESP_OKAY : `PSDC_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule

// >>> dv/psdc_host_model.sv
// Host model for the serial port: clock, data and load strobe.
// Assumes the caller waits out each frame before the next.
`timescale 1ns/1ns
module psdc_host_model (
  output logic ser_clk,
  output logic ser_data,
  output logic load_strobe
);
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    load_strobe = 1'b0;
  end
  // Serial clock stands still outside frames
  task automatic send(input logic [16:0] w);
    #3;
    for (int i = 16; i >= 0; i--) begin
      ser_data <= w[i];
      #16 ser_clk <= 1'b1;
      #16 ser_clk <= 1'b0;
    end
    // Released data line shows the inverse, not a stale bit
    ser_data <= ~w[0];
    #40 load_strobe <= 1'b1;
    #100 load_strobe <= 1'b0;
    #60;
  endtask
endmodule

// >>> dv/psdc_core_checker.sv
// Concurrent checks on the core's bus, comparator and modulus pins.
// Assumes it is bound to the core and sees its ports only.
`timescale 1ns/1ns
module psdc_core_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic fin,
  input wire logic modulus_ctrl,
  input wire logic lock_indicator,
  input wire logic pump_o,
  input wire logic pump_oe,
  input wire logic ref_phase_o,
  input wire logic div_phase_o,
  input wire logic div_phase_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence pump_up;
    pump_oe && pump_o;
  endsequence
  sequence pump_dn;
    pump_oe && !pump_o;
  endsequence
  AST_WR_RESP: assert property (wr_both |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer late or early");
  AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  AST_WR_BLOCK: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("second write let in");
  AST_UP_PAIR: assert property (pump_up |-> !ref_phase_o &&
    div_phase_oe && !div_phase_o) else $error("pump up pair wrong");
  AST_DN_PAIR: assert property (pump_dn |-> ref_phase_o &&
    !div_phase_oe) else $error("pump down pair wrong");
  AST_LOCK: assert property (pump_oe |-> ##[0:1] !lock_indicator)
    else $error("lock stays high while pump active");
  // Change lands some cycles after the fall, well inside the low half
  AST_MOD_FIN: assert property ($changed(modulus_ctrl) |-> !fin)
    else $error("modulus changed away from a falling feedback edge");
endmodule

// >>> dv/test_pll_synth_divider_core.sv
// Bench for the synthesizer core: bus, serial load, divider, comparator.
// Assumes the host model drives the serial pins on its own clock.
`timescale 1ns/1ns
module test_pll_synth_divider_core;
  import psdc_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, fin, osc_input;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [2:0] ref_sel;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, ser_clk, ser_data, load_strobe, osc_output;
  logic modulus_ctrl, prescaler_ratio_select, lock_indicator, pump_o;
  logic pump_oe, ref_phase_o, div_phase_o, div_phase_oe;
  int errors, comparisons, cyc, up_n, dn_n, lo_n, hi_n, u0, d0, h0;
  int fin_per, osc_per, o0, or_n;
  logic osc_q;
  psdc_core dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .ser_clk, .ser_data, .load_strobe, .fin,
    .osc_input, .ref_sel, .osc_output, .modulus_ctrl,
    .prescaler_ratio_select, .lock_indicator, .pump_o, .pump_oe,
    .ref_phase_o, .div_phase_o, .div_phase_oe);
  psdc_host_model host (.ser_clk, .ser_data, .load_strobe);
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Feedback and oscillator made on aclk, well under the sync limit
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    fin <= (cyc % fin_per) >= fin_per / 2;
    osc_input <= (cyc % osc_per) >= osc_per / 2;
    if (cyc % fin_per == 0 && modulus_ctrl === 1'b1) hi_n <= hi_n + 1;
    if (pump_oe === 1'b1 && pump_o === 1'b1) up_n <= up_n + 1;
    if (pump_oe === 1'b1 && pump_o === 1'b0) dn_n <= dn_n + 1;
    if (lock_indicator === 1'b0) lo_n <= lo_n + 1;
    osc_q <= osc_output;
    if (osc_output === 1'b1 && osc_q === 1'b0) or_n <= or_n + 1;
    if (cyc == 60000) begin
      errors++;
      summarize();
    end
  end
  task automatic check_bit(string name, logic exp, logic got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %0b seen %0b", name, exp, got);
    end
  endtask
  task automatic check_word(string name, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    @(posedge aclk);
    while (s_axi_arready !== 1'b1) @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic load_check(input logic [16:0] w);
    host.send(w);
    repeat (2) @(posedge aclk);
    axi_rd(8'h08, rd, resp);
    check_word("word", {15'h0, w}, rd);
  endtask
  function automatic logic ref_faster(logic [2:0] c, int div_cycles);
    int sh[8] = '{0, 1, 3, 4, 5, 6, 7, 8};
    return (8 << sh[c]) * osc_per < div_cycles;
  endfunction
  initial begin
    void'($urandom(32'h298e));
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, fin, osc_input} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    ref_sel = 3'h0;
    {cyc, up_n, dn_n, lo_n, hi_n, errors, comparisons, or_n} = '0;
    osc_q = 1'b0;
    fin_per = 20;
    osc_per = 10;
    aresetn = 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    check_bit("lock_rst", 1'b1, lock_indicator);
    check_bit("osc_rst", 1'b1, osc_output);
    axi_rd(8'h00, rd, resp);
    check_word("ctrl", 32'h2, rd);
    axi_rd(8'h20, rd, resp);
    check_word("unmapped_rd", 32'h0, rd);
    check_word("unmapped_rresp", 32'h2, 32'(resp));
    axi_wr(8'h24, 32'hffffffff, resp);
    check_word("unmapped_wr", 32'h2, 32'(resp));
    // Divider first: a large main count would hold the counters for a
    // thousand feedback periods before a new word takes effect
    load_check({10'h006, 7'h02});
    repeat (6 * fin_per) @(posedge aclk);
    h0 = hi_n;
    repeat (18 * fin_per) @(posedge aclk);
    check_word("mod_hi_periods", 32'd6, 32'(hi_n - h0));
    for (int c = 0; c < 8; c++) begin
      ref_sel <= 3'(c);
      repeat (400) @(posedge aclk);
      axi_rd(8'h04, rd, resp);
      check_bit("sel_top", c == 7, rd[3]);
      u0 = up_n;
      d0 = dn_n;
      o0 = or_n;
      repeat (3000) @(posedge aclk);
      check_bit("pump_up", ref_faster(3'(c), 6 * fin_per),
        (up_n - u0) > (dn_n - d0));
      check_word("osc_rises", 32'(3000 / osc_per), 32'(or_n - o0));
    end
    check_bit("lock_pulse", 1'b1, lo_n > 0);
    // Corner words: all ones, then the smallest main count with no swallow
    load_check(17'h1ffff);
    load_check({10'h005, 7'h00});
    axi_wr(8'h08, 32'h0, resp);
    check_word("ro_wr", 32'h2, 32'(resp));
    load_check({10'(5 + $urandom % 1019), 7'($urandom)});
    load_check({10'(5 + $urandom % 1019), 7'($urandom)});
    // 64/65 mode: the top swallow bit is loaded as zero before the switch
    load_check({10'(5 + $urandom % 1019), 1'b0, 6'($urandom)});
    axi_wr(8'h00, 32'h3, resp);
    check_bit("ratio_sel", 1'b1, prescaler_ratio_select);
    axi_rd(8'h0c, rd, resp);
    check_bit("swal_flag", 1'b0, rd[1]);
    summarize();
  end
endmodule
bind psdc_core psdc_core_checker chk (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .fin, .modulus_ctrl, .lock_indicator,
  .pump_o, .pump_oe, .ref_phase_o, .div_phase_o, .div_phase_oe);
